// *** pkg/rkh_defines.vh ***
`ifndef RKH_DEFINES_VH
`define RKH_DEFINES_VH
`define RKH_ADDR_CTRL 4'h0
`define RKH_ADDR_STATUS 4'h4
`define RKH_ADDR_KEY 4'h8
`define RKH_ADDR_MEDIA 4'hc
`define RKH_CTRL_SUPPORT 0
`define RKH_CTRL_BUSY 1
`define RKH_CTRL_MEDIA_CHANGER 2
`define RKH_CTRL_ROLES_LSB 8
`define RKH_CTRL_RESET 32'h0000_0001
`define RKH_KEY_SELECT 7'h00
`define RKH_KEY_EXIT 7'h0d
`define RKH_KEY_ROOT 7'h09
`define RKH_KEY_DIGIT0 7'h20
`define RKH_KEY_DIGIT9 7'h29
`define RKH_KEY_ENTER 7'h2b
`define RKH_KEY_CLEAR 7'h2c
`define RKH_KEY_FORWARD 7'h4b
`define RKH_KEY_BACKWARD 7'h4c
`define RKH_KEY_MEDIA_SELECT 7'h68
`define RKH_CLK_HZ 20000000
`define RKH_HOLD_DETECT_MS 300
`define RKH_HOLD_MAINTAIN_MS 550
`define RKH_MEDIA_TIMEOUT_S 5
`define RKH_REPEAT_MS 500
// Cycle counts at 20 MHz for 300 ms, 550 ms, 5 s and 500 ms, sized for the timers
`define RKH_HOLD_DETECT_CYC 28'h05b8d80
`define RKH_HOLD_MAINTAIN_CYC 28'h0a7d8c0
`define RKH_MEDIA_TIMEOUT_CYC 28'h5f5e100
`define RKH_REPEAT_CYC 28'h0989680
`define RKH_ERR_INEFFECTIVE 8'h01
`endif

// *** src/rkh_key_class.v ***
`include "rkh_defines.vh"
// Classifies a 7-bit key identifier against role support and hold list
module rkh_key_class (
   input wire [6:0] key_id,
   input wire [7:0] roles,
   output reg supported,
   output reg hold_key
);
   reg digit;
   // Role-dependent support and press-and-hold membership
   always @* begin
      digit = (key_id >= `RKH_KEY_DIGIT0) && (key_id <= `RKH_KEY_DIGIT9);
      supported = 1'b0;
      if (roles[7] && (key_id <= 7'h04 || key_id == `RKH_KEY_ROOT ||
          key_id == `RKH_KEY_EXIT)) begin
         supported = 1'b1;
      end
      if ((|roles[4:1]) && (digit || key_id == `RKH_KEY_ENTER ||
          key_id == `RKH_KEY_CLEAR)) begin
         supported = 1'b1;
      end
      if ((key_id >= 7'h30 && key_id <= 7'h33) || (key_id >= 7'h41 && key_id <= 7'h4c) ||
          (key_id >= 7'h60 && key_id <= 7'h66) || key_id == `RKH_KEY_MEDIA_SELECT) begin
         supported = 1'b1;
      end
      hold_key = (key_id >= 7'h01 && key_id <= 7'h08) || key_id == 7'h30 ||
         key_id == 7'h31 || key_id == 7'h37 || key_id == 7'h38 ||
         key_id == 7'h41 || key_id == 7'h42 || (key_id >= 7'h48 && key_id <= 7'h49) ||
         key_id == 7'h4b || key_id == 7'h4c;
   end
endmodule // rkh_key_class

// *** src/rkh_timer.v ***
// Down counter: load restarts it, done pulses one cycle on expiry
module rkh_timer #(
   parameter [27:0] COUNT = 28'h0000010
) (
   input wire hclk,
   input wire hresetn,
   input wire load,
   input wire stop,
   output reg done
);
   reg [27:0] count;
   reg running;
   // Count down while running
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= 28'h0000000;
         running <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin
            count <= COUNT;
            running <= 1'b1;
         end else if (stop) begin
            running <= 1'b0;
         end else if (running) begin
            if (count <= 28'h0000001) begin
               running <= 1'b0;
               done <= 1'b1;
            end else begin
               count <= count - 28'h0000001;
            end
         end
      end
   end
endmodule // rkh_timer

// *** src/rkh_handler.v ***
// Local design decisions: the register offsets and register access over AHB-Lite.
`include "rkh_defines.vh"
// Remote key press-and-hold handler with AHB-Lite register slave
module rkh_handler #(
   parameter [27:0] HOLD_DETECT_CYC = `RKH_HOLD_DETECT_CYC,
   parameter [27:0] HOLD_MAINTAIN_CYC = `RKH_HOLD_MAINTAIN_CYC,
   parameter [27:0] MEDIA_TIMEOUT_CYC = `RKH_MEDIA_TIMEOUT_CYC,
   parameter [27:0] REPEAT_CYC = `RKH_REPEAT_CYC
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   input wire key_valid,
   input wire [7:0] key_code,
   output reg key_ack,
   output reg [7:0] key_ack_code,
   output reg key_error,
   output reg [7:0] key_error_code,
   output reg key_nack,
   output reg action_valid,
   output reg [6:0] action_key,
   output reg action_repeat,
   output reg hold_active,
   output reg media_mode,
   output reg media_select_valid,
   output reg [1:0] media_select_kind,
   output reg [15:0] media_index
);
   // Key state machine codes
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_PENDING = 3'h1;
   localparam [2:0] ST_DETECT = 3'h2;
   localparam [2:0] ST_HOLD = 3'h3;

   // Control word, key state, queue and media entry
   reg [31:0] ctrl;
   reg [2:0] state;
   reg [7:0] first_key;
   reg [7:0] queued_key;
   reg queued;
   reg [3:0] wr_addr;
   reg wr_pend;
   reg [15:0] digit_acc;
   reg digits_seen;
   reg [31:0] key_count;
   reg [31:0] next_rdata;

   // Incoming key fields, classifier results and timer expiries
   wire [6:0] key_id = key_code[6:0];
   wire key_release = key_code[7];
   wire in_support;
   wire pend_support;
   wire pend_hold;
   wire detect_done;
   wire maintain_done;
   wire media_done;
   wire repeat_done;
   wire accept = key_valid && ctrl[`RKH_CTRL_SUPPORT] && !ctrl[`RKH_CTRL_BUSY];
   wire new_supported = in_support || (ctrl[`RKH_CTRL_MEDIA_CHANGER] &&
      (key_id == `RKH_KEY_MEDIA_SELECT || key_id == `RKH_KEY_FORWARD ||
       key_id == `RKH_KEY_BACKWARD || key_id == `RKH_KEY_ENTER ||
       (key_id >= `RKH_KEY_DIGIT0 && key_id <= `RKH_KEY_DIGIT9)));
   wire ahb_go = hsel && hready && htrans[1];
   wire addr_hit = (haddr[31:4] == 28'h0000000);
   reg load_detect;
   reg load_maintain;
   reg stop_timers;
   reg load_media;
   reg load_repeat;

   // Support check of the key arriving now
   rkh_key_class u_class_in (
      .key_id(key_id),
      .roles(ctrl[15:8]),
      .supported(in_support),
      .hold_key()
   );

   // Normal or press-and-hold class of the pending first key
   rkh_key_class u_class_pend (
      .key_id(first_key[6:0]),
      .roles(ctrl[15:8]),
      .supported(pend_support),
      .hold_key(pend_hold)
   );

   // Waits for a second key before hold mode starts
   rkh_timer #(.COUNT(HOLD_DETECT_CYC)) u_detect (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(load_detect),
      .stop(stop_timers),
      .done(detect_done)
   );

   // Ends hold mode when the press code stops coming
   rkh_timer #(.COUNT(HOLD_MAINTAIN_CYC)) u_maintain (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(load_maintain),
      .stop(stop_timers),
      .done(maintain_done)
   );

   // Ends media selection after a quiet spell
   rkh_timer #(.COUNT(MEDIA_TIMEOUT_CYC)) u_media (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(load_media),
      .stop(!media_mode),
      .done(media_done)
   );

   // Paces repeated actions while a key is held
   rkh_timer #(.COUNT(REPEAT_CYC)) u_repeat (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(load_repeat),
      .stop(stop_timers),
      .done(repeat_done)
   );

   // AHB-Lite slave: zero wait states, always OKAY, writes land in data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         wr_pend <= 1'b0;
         wr_addr <= 4'h0;
         ctrl <= `RKH_CTRL_RESET;
      end else begin
         wr_pend <= ahb_go && hwrite && addr_hit;
         wr_addr <= haddr[3:0];
         if (wr_pend && wr_addr == `RKH_ADDR_CTRL) begin
            ctrl <= {16'h0000, hwdata[15:8], 5'h00, hwdata[2:0]};
         end
         if (ahb_go && !hwrite) begin
            hrdata <= next_rdata;
         end
      end
   end

   // Read data for the address phase; offsets outside the map read as zero
   always @* begin
      next_rdata = 32'h0000_0000;
      if (addr_hit) begin
         case (haddr[3:0])
            `RKH_ADDR_CTRL: next_rdata = ctrl;
            `RKH_ADDR_STATUS: next_rdata = {26'h0, digits_seen, media_mode,
               queued, state};
            `RKH_ADDR_KEY: next_rdata = {key_count[23:0], first_key};
            `RKH_ADDR_MEDIA: next_rdata = {16'h0000, media_index};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Timer control from the key state machine
   always @* begin
      load_detect = 1'b0;
      load_maintain = 1'b0;
      stop_timers = 1'b0;
      load_repeat = 1'b0;
      // Media timer starts on entry and restarts on every key inside the mode
      load_media = accept && ctrl[`RKH_CTRL_MEDIA_CHANGER] &&
         (media_mode || (!key_release && key_id == `RKH_KEY_MEDIA_SELECT));
      if (state == ST_PENDING && pend_hold && !first_key[7]) begin
         load_detect = 1'b1;
      end
      if (state == ST_DETECT && (detect_done || (accept && key_code == first_key))) begin
         load_maintain = 1'b1;
         load_repeat = 1'b1;
      end
      if (state == ST_HOLD && accept && key_code == first_key) begin
         load_maintain = 1'b1;
      end
      if (state == ST_HOLD && repeat_done) begin
         load_repeat = 1'b1;
      end
      if (state == ST_IDLE) begin
         stop_timers = 1'b1;
      end
   end

   // Key state machine, responses and media selection
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
         first_key <= 8'h00;
         queued_key <= 8'h00;
         queued <= 1'b0;
         key_ack <= 1'b0;
         key_ack_code <= 8'h00;
         key_error <= 1'b0;
         key_error_code <= 8'h00;
         key_nack <= 1'b0;
         action_valid <= 1'b0;
         action_key <= 7'h00;
         action_repeat <= 1'b0;
         hold_active <= 1'b0;
         media_mode <= 1'b0;
         media_select_valid <= 1'b0;
         media_select_kind <= 2'h0;
         media_index <= 16'h0000;
         digit_acc <= 16'h0000;
         digits_seen <= 1'b0;
         key_count <= 32'h0000_0000;
      end else begin
         // Every answer and action is a one-cycle pulse
         key_ack <= 1'b0;
         key_error <= 1'b0;
         key_nack <= 1'b0;
         action_valid <= 1'b0;
         action_repeat <= 1'b0;
         media_select_valid <= 1'b0;
         // Answer each key with nack, ack or error; a key that arrives while busy with support set gets no answer
         if (key_valid && !ctrl[`RKH_CTRL_SUPPORT]) begin
            key_nack <= 1'b1;
         end
         if (accept) begin
            key_count <= key_count + 32'h0000_0001;
            key_ack_code <= key_code;
            if (new_supported || key_release) begin
               key_ack <= 1'b1;
            end else begin
               key_error <= 1'b1;
               key_error_code <= `RKH_ERR_INEFFECTIVE;
            end
         end
         // Media selection mode, ends on enter, forward, backward, media select after digits or timeout
         if (accept && !key_release && ctrl[`RKH_CTRL_MEDIA_CHANGER]) begin
            if (!media_mode && key_id == `RKH_KEY_MEDIA_SELECT) begin
               media_mode <= 1'b1;
               digit_acc <= 16'h0000;
               digits_seen <= 1'b0;
            end else if (media_mode) begin
               if (key_id >= `RKH_KEY_DIGIT0 && key_id <= `RKH_KEY_DIGIT9) begin
                  digit_acc <= (digit_acc << 3) + (digit_acc << 1) +
                     {12'h000, key_id[3:0]};
                  digits_seen <= 1'b1;
               end else if (key_id == `RKH_KEY_ENTER && digits_seen) begin
                  media_mode <= 1'b0;
                  media_index <= digit_acc;
                  media_select_valid <= 1'b1;
                  media_select_kind <= 2'h0;
               end else if (key_id == `RKH_KEY_FORWARD) begin
                  media_mode <= 1'b0;
                  media_index <= media_index + 16'h0001;
                  media_select_valid <= 1'b1;
                  media_select_kind <= 2'h1;
               end else if (key_id == `RKH_KEY_BACKWARD) begin
                  media_mode <= 1'b0;
                  media_index <= media_index - 16'h0001;
                  media_select_valid <= 1'b1;
                  media_select_kind <= 2'h2;
               end else if (key_id == `RKH_KEY_MEDIA_SELECT && digits_seen) begin
                  media_mode <= 1'b0;
               end else if (key_id == `RKH_KEY_ENTER) begin
                  media_mode <= 1'b0;
               end
            end
         end else if (media_done) begin
            media_mode <= 1'b0;
         end
         // Press-and-hold state machine
         case (state)
            ST_IDLE: begin
               hold_active <= 1'b0;
               if (queued) begin
                  first_key <= queued_key;
                  queued <= 1'b0;
                  state <= ST_PENDING;
               end else if (accept) begin
                  first_key <= key_code;
                  state <= ST_PENDING;
               end
            end
            ST_PENDING: begin
               if (pend_hold && !first_key[7]) begin
                  state <= ST_DETECT;
               end else begin
                  if (!first_key[7] && pend_support) begin
                     action_valid <= 1'b1;
                     action_key <= first_key[6:0];
                  end
                  if (accept) begin
                     queued_key <= key_code; // Early key waits for idle
                     queued <= 1'b1;
                  end
                  state <= ST_IDLE;
               end
            end
            ST_DETECT: begin
               if (accept) begin
                  if (key_code == {1'b1, first_key[6:0]}) begin
                     action_valid <= 1'b1;
                     action_key <= first_key[6:0];
                     state <= ST_IDLE;
                  end else if (key_code == first_key) begin
                     hold_active <= 1'b1;
                     state <= ST_HOLD;
                  end else begin
                     action_valid <= 1'b1;
                     action_key <= first_key[6:0];
                     first_key <= key_code;
                     state <= ST_PENDING;
                  end
               end else if (detect_done) begin
                  hold_active <= 1'b1;
                  state <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (accept) begin
                  if (key_code == {1'b1, first_key[6:0]}) begin
                     hold_active <= 1'b0;
                     state <= ST_IDLE;
                  end else if (key_code != first_key) begin
                     hold_active <= 1'b0;
                     first_key <= key_code;
                     state <= ST_PENDING;
                  end
               end else if (maintain_done) begin
                  hold_active <= 1'b0;
                  state <= ST_IDLE;
               end else if (repeat_done) begin
                  action_valid <= 1'b1;
                  action_repeat <= 1'b1;
                  action_key <= first_key[6:0];
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule // rkh_handler

// *** verification/rkh_peer.sv ***
// Far-side sender: one key message per call, then the spacing the receiver needs
module rkh_peer (
   input wire hclk,
   output logic key_valid,
   output logic [7:0] key_code
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      key_valid = 1'b0;
      key_code = 8'h00;
   end
   // Pulse one code; afterwards the idle line shows the inverse, never the old code
   task automatic send(input logic [7:0] code);
      @(posedge hclk);
      key_valid <= 1'b1;
      key_code <= code;
      @(posedge hclk);
      key_valid <= 1'b0;
      key_code <= ~code;
      repeat (4) @(posedge hclk);
   endtask
endmodule // rkh_peer

// *** verification/rkh_handler_sva.sv ***
// Checks answer timing, hold exit and media exit at the handler ports
module rkh_sva #(
   parameter [27:0] HOLD_MAINTAIN_CYC = 28'h0000028,
   parameter [27:0] MEDIA_TIMEOUT_CYC = 28'h000003c
) (
   input wire hclk,
   input wire hresetn,
   input wire hreadyout,
   input wire hresp,
   input wire key_valid,
   input wire [7:0] key_code,
   input wire key_ack,
   input wire [7:0] key_ack_code,
   input wire key_error,
   input wire [7:0] key_error_code,
   input wire key_nack,
   input wire action_repeat,
   input wire hold_active,
   input wire media_mode,
   input wire media_select_valid,
   input wire [1:0] media_select_kind
);
   reg [27:0] hold_cnt;
   reg [27:0] media_cnt;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Quiet cycles spent in hold mode and in media mode
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_cnt <= 28'h0;
         media_cnt <= 28'h0;
      end else begin
         hold_cnt <= (!hold_active || key_valid) ? 28'h0 : hold_cnt + 28'h1;
         media_cnt <= (!media_mode || key_valid) ? 28'h0 : media_cnt + 28'h1;
      end
   end
   ack_echo_a: assert property (key_ack |-> $past(key_valid) && key_ack_code == $past(key_code))
      else $error("ack without key or wrong echo");
   ack_excl_a: assert property (key_ack |-> !key_error && !key_nack)
      else $error("ack together with error or nack");
   nack_cause_a: assert property (key_nack |-> $past(key_valid) && !key_ack && !key_error)
      else $error("nack without key");
   error_code_a: assert property (key_error |-> $past(key_valid) && key_error_code == 8'h01)
      else $error("error answer wrong");
   release_exit_a: assert property ((hold_active && key_valid && !key_ack_code[7] &&
      key_code == {1'b1, key_ack_code[6:0]}) ##1 key_ack |-> ##[0:2] !hold_active)
      else $error("release did not end hold");
   hold_timer_a: assert property (hold_cnt <= HOLD_MAINTAIN_CYC + 28'h4)
      else $error("hold mode outlived its timer");
   repeat_hold_a: assert property (action_repeat |-> hold_active)
      else $error("repeat outside hold");
   media_end_a: assert property (media_select_valid |-> media_select_kind != 2'h3 ##[0:1] !media_mode)
      else $error("media select did not end mode");
   media_timer_a: assert property (media_cnt <= MEDIA_TIMEOUT_CYC + 28'h4)
      else $error("media mode outlived its timeout");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
endmodule // rkh_sva
bind rkh_handler rkh_sva #(.HOLD_MAINTAIN_CYC(HOLD_MAINTAIN_CYC),
   .MEDIA_TIMEOUT_CYC(MEDIA_TIMEOUT_CYC)) chk (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .key_valid(key_valid), .key_code(key_code),
   .key_ack(key_ack), .key_ack_code(key_ack_code), .key_error(key_error),
   .key_error_code(key_error_code), .key_nack(key_nack), .action_repeat(action_repeat),
   .hold_active(hold_active), .media_mode(media_mode),
   .media_select_valid(media_select_valid), .media_select_kind(media_select_kind));

// *** verification/remote_key_press_hold_handler_test.sv ***
module remote_key_press_hold_handler_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 1'b0, hresetn = 1'b0, hsel, hwrite;
   logic [31:0] haddr, hwdata, rd;
   logic [1:0] htrans, kind_s;
   logic [2:0] hsize;
   logic [6:0] last_act;
   wire hreadyout, hresp, key_valid, key_ack, key_error, key_nack, action_valid, action_repeat;
   wire hold_active, media_mode, media_select_valid;
   wire [31:0] hrdata;
   wire [7:0] key_code, key_ack_code, key_error_code;
   wire [6:0] action_key;
   wire [1:0] media_select_kind;
   wire [15:0] media_index;
   integer errors = 0, n_checks = 0, n_act = 0, n_ack = 0, n_err = 0, n_nack = 0;
   integer n_rep = 0, n_sel = 0, a0, k0;
   rkh_handler #(.HOLD_DETECT_CYC(28'h14), .HOLD_MAINTAIN_CYC(28'h28),
      .MEDIA_TIMEOUT_CYC(28'h3c), .REPEAT_CYC(28'h8)) uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .key_valid(key_valid),
      .key_code(key_code), .key_ack(key_ack), .key_ack_code(key_ack_code),
      .key_error(key_error), .key_error_code(key_error_code), .key_nack(key_nack),
      .action_valid(action_valid), .action_key(action_key), .action_repeat(action_repeat),
      .hold_active(hold_active), .media_mode(media_mode),
      .media_select_valid(media_select_valid), .media_select_kind(media_select_kind),
      .media_index(media_index));
   rkh_peer peer (.hclk(hclk), .key_valid(key_valid), .key_code(key_code));
   always #25 hclk = ~hclk;
   // Count every answer pulse the handler gives
   always @(posedge hclk) begin
      n_ack += (key_ack === 1'b1);
      n_err += (key_error === 1'b1);
      n_nack += (key_nack === 1'b1);
      n_rep += (action_repeat === 1'b1);
      if (action_valid === 1'b1) begin
         n_act++;
         last_act = action_key;
      end
      if (media_select_valid === 1'b1) begin
         n_sel++;
         kind_s = media_select_kind;
      end
   end
   task summarize;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask
   // Single AHB-Lite word transfer; read data taken at the end of the data phase
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      integer i;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      for (i = 0; i < 2; i++) begin
         @(posedge hclk);
         while (hreadyout !== 1'b1 && i < 40) begin
            @(posedge hclk);
            i += 2;
         end
         if (i >= 40) begin
            chk("hready", 32'h1, hreadyout);
            summarize;
         end
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
      end
      rd = hrdata;
   endtask
   // Bounded wait on hold_active or media_mode
   task wait_lvl(input logic m, input logic exp, input integer lim);
      integer i;
      for (i = 0; i < lim && (m ? media_mode : hold_active) !== exp; i++) @(posedge hclk);
      chk(m ? "media_mode" : "hold_active", exp, m ? media_mode : hold_active);
      if (i == lim) summarize;
   endtask
   task t_bus;
      ahb(1'b0, 32'h0, 32'h0);
      chk("ctrl reset", 32'h1, rd);
      ahb(1'b0, 32'h4, 32'h0);
      chk("status reset", 32'h0, rd);
      ahb(1'b1, 32'h10, 32'hffff_ffff);
      ahb(1'b1, 32'h0, 32'h0000_0201);
      ahb(1'b0, 32'h0, 32'h0);
      chk("ctrl", 32'h0000_0201, rd);
      ahb(1'b0, 32'h10, 32'h0);
      chk("unmapped", 32'h0, rd);
   endtask
   task t_keys;
      a0 = n_act;
      k0 = n_ack;
      peer.send(8'h44);
      chk("ack count", k0 + 1, n_ack);
      chk("ack code", 32'h44, key_ack_code);
      chk("action key", 32'h44, last_act);
      peer.send(8'h41);
      peer.send(8'hc1);
      repeat (25) @(posedge hclk);
      chk("short press actions", a0 + 2, n_act);
      chk("hold after release", 32'h0, hold_active);
      peer.send(8'h41);
      peer.send(8'h44);
      chk("first then second", a0 + 4, n_act);
      chk("promoted key", 32'h44, last_act);
      k0 = n_err;
      peer.send(8'h0e);
      peer.send(8'h00);
      chk("error count", k0 + 2, n_err);
      ahb(1'b1, 32'h0, 32'h0000_8201);
      peer.send(8'h00);
      chk("menu key", 32'h00, last_act);
      ahb(1'b1, 32'h0, 32'h0);
      k0 = n_ack;
      peer.send(8'h44);
      chk("nack", 32'h1, n_nack);
      chk("no ack", k0, n_ack);
   endtask
   task t_hold;
      ahb(1'b1, 32'h0, 32'h0000_0201);
      peer.send(8'h41);
      wait_lvl(1'b0, 1'b1, 40);
      repeat (3) begin
         repeat (25) @(posedge hclk);
         peer.send(8'h41);
         chk("hold kept", 32'h1, hold_active);
      end
      chk("repeats seen", 32'h1, n_rep > 0);
      peer.send(8'hc1);
      chk("hold released", 32'h0, hold_active);
      peer.send(8'h42);
      wait_lvl(1'b0, 1'b1, 40);
      wait_lvl(1'b0, 1'b0, 60);
      peer.send(8'h41);
      peer.send(8'h41);
      chk("repeat press", 32'h1, hold_active);
      a0 = n_act;
      peer.send(8'h44);
      chk("other key exits", 32'h0, hold_active);
      chk("new key acted", 32'h44, last_act);
      chk("one action after exit", a0 + 1, n_act);
   endtask
   task t_media;
      ahb(1'b1, 32'h0, 32'h0000_0805);
      peer.send(8'h68);
      chk("media entry", 32'h1, media_mode);
      peer.send(8'h24);
      peer.send(8'h21);
      peer.send(8'h2b);
      chk("index select", 32'h1, n_sel);
      chk("index kind", 32'h0, kind_s);
      chk("index", 32'd41, media_index);
      chk("mode ended", 32'h0, media_mode);
      peer.send(8'h68);
      peer.send(8'h4b);
      chk("forward kind", 32'h1, kind_s);
      peer.send(8'h68);
      peer.send(8'h4c);
      chk("backward kind", 32'h2, kind_s);
      peer.send(8'h68);
      peer.send(8'h23);
      peer.send(8'h68);
      chk("escape mode", 32'h0, media_mode);
      chk("escape no select", 32'h3, n_sel);
      peer.send(8'h68);
      wait_lvl(1'b1, 1'b0, 80);
   endtask
   // Reset for three cycles, then run every scenario
   initial begin
      hsel <= 1'b0;
      hwrite <= 1'b0;
      haddr <= 32'h0;
      hwdata <= 32'h0;
      htrans <= 2'h0;
      hsize <= 3'h2;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_bus;
      t_keys;
      t_hold;
      t_media;
      summarize;
   end
endmodule // remote_key_press_hold_handler_test
